// >>> core/dma_request_ack_handshake.v
// four-channel dma request arbitration and acknowledge handshake
//
// Operation
// - four request inputs, index equals channel
// - highest priority simultaneous request serviced first
// - four acknowledge outputs, one per channel
// - acknowledge only on requester-side access
// - asserted request starts arbitrated transfer
`timescale 1ns/100ps
`default_nettype none
`include "dma_handshake_consts.vh"

module dma_request_ack_handshake (
  // clock and reset
  input  wire                         core_clk,
  input  wire                         rstn,
  // peripheral pins, active low
  input  wire [`NUM_CHAN-1:0]         channel_request_lines_n,
  output reg  [`NUM_CHAN-1:0]         channel_acknowledge_lines_n,
  // priority configuration, two bits per channel, lower wins
  input  wire [`NUM_CHAN*`PRIO_W-1:0] chan_priority,
  // access sequencer: requester side flag per access
  input  wire                         access_is_requester_side,
  output wire                         busy,
  output reg  [`PRIO_W-1:0]           active_chan_q
);

  localparam ST_IDLE   = 3'b001;
  localparam ST_SRC    = 3'b010;
  localparam ST_DST    = 3'b100;

  ////////////////////////////////////////////////////////////////
  // synchronise the asynchronous request pins
  reg  [`NUM_CHAN-1:0] req_meta_q;
  reg  [`NUM_CHAN-1:0] req_sync_q;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_meta_q <= {`NUM_CHAN{1'b0}};
      req_sync_q <= {`NUM_CHAN{1'b0}};
    end else begin
      req_meta_q <= ~channel_request_lines_n;
      req_sync_q <= req_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // priority arbitration
  function [`PRIO_W-1:0] prio_of;
    input [`NUM_CHAN*`PRIO_W-1:0] cfg;
    input integer                 ch;
    begin
      prio_of = cfg[ch*`PRIO_W +: `PRIO_W];
    end
  endfunction

  reg                 win_valid;
  reg [`PRIO_W-1:0]   win_chan;
  reg [`PRIO_W-1:0]   win_prio;
  integer             i;

  // ties go to the lower channel index so the choice is always unique
  always @* begin
    win_valid = 1'b0;
    win_chan  = {`PRIO_W{1'b0}};
    win_prio  = {`PRIO_W{1'b1}};
    for (i = 0; i < `NUM_CHAN; i = i + 1) begin
      if (req_sync_q[i] &&
          (!win_valid || prio_of(chan_priority, i) < win_prio)) begin
        win_valid = 1'b1;
        win_chan  = i[`PRIO_W-1:0];
        win_prio  = prio_of(chan_priority, i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // transfer sequencer: one source access then one destination access
  reg [2:0]                 state_q;
  reg [2:0]                 state_d;
  reg [`ACCESS_CNT_W-1:0]   cnt_q;
  reg [`ACCESS_CNT_W-1:0]   cnt_d;
  reg                       settle_q;
  reg                       settle_d;
  wire                      in_idle;
  wire                      cnt_done;
  wire                      xfer_end;
  wire                      grant;

  assign in_idle  = (state_q == ST_IDLE);
  assign cnt_done = (cnt_q == `ACCESS_CYCLES - 3'h1);
  assign xfer_end = (state_q == ST_DST) && cnt_done;

  // request pins lag two flops behind the peripheral, so right after a
  // transfer the served channel can still look pending;
  // one quiet idle cycle hides that stale request
  assign grant = in_idle && win_valid && !settle_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (grant) begin
          state_d = ST_SRC;
        end
      end
      ST_SRC: begin
        if (cnt_done) begin
          state_d = ST_DST;
        end
      end
      ST_DST: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // access length counter, cleared between accesses
  always @* begin
    if (in_idle) begin
      cnt_d = {`ACCESS_CNT_W{1'b0}};
    end else if (cnt_done) begin
      cnt_d = {`ACCESS_CNT_W{1'b0}};
    end else begin
      cnt_d = cnt_q + 3'h1;
    end
  end

  // hold-off for the cycle that follows a destination access
  always @* begin
    settle_d = xfer_end;
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q  <= ST_IDLE;
      cnt_q    <= {`ACCESS_CNT_W{1'b0}};
      settle_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      settle_q <= settle_d;
    end
  end

  assign busy = !in_idle;

  ////////////////////////////////////////////////////////////////
  // grant capture
  // the access flag is sampled at grant so a transfer never splits sides;
  // priority changes mid-transfer only steer the next grant
  reg req_side_src_q;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      active_chan_q  <= {`PRIO_W{1'b0}};
      req_side_src_q <= 1'b0;
    end else begin
      if (grant) begin
        active_chan_q  <= win_chan;
        req_side_src_q <= access_is_requester_side;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // acknowledge outputs, registered, active low
  function chan_hit;
    input [`PRIO_W-1:0] sel;
    input integer       ch;
    begin
      chan_hit = (sel == ch[`PRIO_W-1:0]);
    end
  endfunction

  // side and channel of the access that starts at the next edge
  reg                  next_side_src;
  reg  [`PRIO_W-1:0]   next_chan;
  wire                 next_req_access;
  wire [`NUM_CHAN-1:0] ack_d;
  genvar               g;

  always @* begin
    if (in_idle) begin
      next_side_src = access_is_requester_side;
      next_chan     = win_chan;
    end else begin
      next_side_src = req_side_src_q;
      next_chan     = active_chan_q;
    end
  end

  // only the access that touches the requester is acknowledged
  assign next_req_access = (state_d == ST_SRC &&  next_side_src) ||
                           (state_d == ST_DST && !next_side_src);

  generate
    for (g = 0; g < `NUM_CHAN; g = g + 1) begin : g_ack
      assign ack_d[g] = next_req_access && chan_hit(next_chan, g);
    end
  endgenerate

  // decided a cycle early from state_d so the pins come straight from flops
  // and never glitch; the cost is a longer path into the ack flops
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_acknowledge_lines_n <= `ACK_INACTIVE;
    end else begin
      channel_acknowledge_lines_n <= ~ack_d;
    end
  end

endmodule
`default_nettype wire

// >>> core/dma_handshake_consts.vh
// constants for the dma request/acknowledge handshake block
`ifndef DMA_HANDSHAKE_CONSTS_VH
`define DMA_HANDSHAKE_CONSTS_VH

`define NUM_CHAN          4
`define PRIO_W            2
// default priority per channel: channel 0 highest (lower value wins)
`define PRIO_RESET        8'he4
// bus access length in clock cycles
`define ACCESS_CYCLES     3'h2
`define ACCESS_CNT_W      3
`define ACK_INACTIVE      4'hf

`endif

// >>> tb/dma_request_ack_handshake_props.sv
// port assertions for the dma handshake block
`timescale 1ns/100ps
`default_nettype none
module dma_request_ack_handshake_props (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [3:0] channel_request_lines_n,
  input wire logic [3:0] channel_acknowledge_lines_n,
  input wire logic       access_is_requester_side,
  input wire logic       busy,
  input wire logic [1:0] active_chan_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire [3:0] a = ~channel_acknowledge_lines_n;
  AST_CHAN: assert property (|a |-> a == 4'h1 << active_chan_q) else $error("ack chan");
  AST_BUSY: assert property (|a |-> busy) else $error("ack idle");
  AST_LEN: assert property ($rose(|a) |=> |a ##1 !a) else $error("ack len");
  AST_SIDE: assert property ($rose(busy) |-> (|a) == access_is_requester_side)
    else $error("ack side");
  AST_GO: assert property (channel_request_lines_n != 4'hf && !busy |-> ##[0:3] busy)
    else $error("no grant");
  AST_REQ: assert property ($rose(busy) |-> (~$past(channel_request_lines_n, 2) & (4'h1 << active_chan_q)) != 4'h0)
    else $error("bad grant");
  cover property ($rose(busy) && access_is_requester_side);
  cover property ($rose(busy) && !access_is_requester_side);
  cover property (channel_request_lines_n == 4'h0);
endmodule
bind dma_request_ack_handshake dma_request_ack_handshake_props u_props (.*);
`default_nettype wire

// >>> tb/periph_model.sv
// peripheral model: request held until acknowledged
`timescale 1ns/100ps
`default_nettype none
module periph_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] go,
  input  wire logic [3:0] ack_n,
  output var  logic [3:0] req_n
);
  initial req_n = 4'hf;
  always @(posedge core_clk) req_n <= (req_n | ~ack_n) & ~go;
endmodule
`default_nettype wire

// >>> tb/tb_dma_request_ack_handshake.sv
// self-checking bench for the dma handshake block
`timescale 1ns/100ps
`default_nettype none
module tb_dma_request_ack_handshake;
  reg        core_clk = 0, rstn = 0, side = 1;
  reg  [3:0] go = 4'h0;
  reg  [7:0] prio = 8'he4;
  wire [3:0] req_n, ack_n;
  wire [1:0] ch;
  wire       busy;
  integer    failures = 0, samples_checked = 0, i, k;
  always #4 core_clk = ~core_clk;
  dma_request_ack_handshake u_dut (.core_clk(core_clk), .rstn(rstn), .busy(busy),
    .channel_request_lines_n(req_n), .channel_acknowledge_lines_n(ack_n),
    .chan_priority(prio), .access_is_requester_side(side), .active_chan_q(ch));
  periph_model u_periph (.core_clk(core_clk), .go(go), .ack_n(ack_n), .req_n(req_n));
  task test_done;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [6:0] got, input [6:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) failures = failures + 1;
    if (got !== exp) $display("Error t=%0t got %h exp %h", $time, got, exp);
  endtask
  // let the running ack end first so a grant is never judged twice
  task wack(input [3:0] g, input [1:0] c);
    @(posedge core_clk) go <= g;
    @(posedge core_clk) go <= 4'h0;
    for (i = 0; i < 40 && ack_n !== 4'hf; i = i + 1) @(posedge core_clk) #1;
    for (i = 0; i < 40 && ack_n === 4'hf; i = i + 1) @(posedge core_clk) #1;
    chk({busy, ch, ack_n}, {1'b1, c, ~(4'h1 << c)});
  endtask
  task t_each;
    for (k = 0; k < 4; k = k + 1) wack(4'h1 << k, k[1:0]);
  endtask
  task t_prio(input [7:0] p, input [7:0] ord);
    @(posedge core_clk) prio <= p;
    wack(4'hf, ord[1:0]);
    for (k = 1; k < 4; k = k + 1) wack(4'h0, ord[2*k +: 2]);
  endtask
  task t_side;
    @(posedge core_clk) side <= 1'b0;
    wack(4'h2, 2'h1);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    t_prio(8'h1b, 8'h1b);
    t_prio(8'h00, 8'he4);
    t_each;
    t_side;
    test_done;
  end
  initial begin
    #20000 failures = failures + 1;
    test_done;
  end
endmodule
`default_nettype wire
